// [common/rx_chain_params.svh]
// Purpose : constants of the receive signal chain control block
// Assumes : included by the package and by every design file that needs a number
// Notes   : definitions only, guarded against double inclusion
`ifndef RX_CHAIN_PARAMS_SVH
`define RX_CHAIN_PARAMS_SVH

// ----------------------------------------------------------------
// register map, byte offsets on the register port
// ----------------------------------------------------------------
`define ADDR_W          10
`define REG_MODE        10'h13E
`define REG_READBACK    10'h30C
`define REG_DIGFILT     10'h389
`define REG_ANAFILT     10'h39B
`define REG_AVGCFG      10'h3B9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ANA_BW_MSB      3
`define ANA_BW_LSB      0
`define DIG1_MSB        1
`define DIG1_LSB        0
`define DIG2_MSB        4
`define DIG2_LSB        2
`define AVG_TIME_MSB    1
`define AVG_TIME_LSB    0
`define OFFS_MSB        4
`define OFFS_LSB        2
`define AVG1_MSB        7
`define AVG1_LSB        5

// ----------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------
`define MODE_RST        8'h00
`define DIGFILT_RST     8'h00
`define ANAFILT_RST     8'h00
`define AVGCFG_RST      8'h00
`define MODE_PKT_154    8'h00
`define MODE_FSK        8'h03
`define RSSI_MAX        9'sh07F
`define RSSI_MIN        -9'sh080

// ----------------------------------------------------------------
// timing: times in ns, cycle counts derived in the logic
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   32'd100
`define AVG_UNIT_NS     32'd77
`define ALPHA_BASE      5'd2
`define IEEE_AVG_NS     32'd128000
`define SYMBOL_NS       32'd16000
`define FRAME_SYMBOLS   32'd8

`endif

// [common/rx_chain_pkg.sv]
// Purpose : types shared by the receive signal chain control files
// Assumes : constants come from rx_chain_params.svh
// Notes   : every design module keeps its whole state in one packed struct
`include "rx_chain_params.svh"

package rx_chain_pkg;

  // ----------------------------------------------------------------
  // receive sequencing phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // receiver off, correction held
    ST_CAL  = 2'b01,  // offset correction phase
    ST_RX   = 2'b10   // active receive, gain control on
  } rx_phase_t;

  // main block state
  typedef struct packed {
    rx_phase_t  phase;
    logic [7:0] mode_reg;
    logic [7:0] dig_reg;
    logic [7:0] ana_reg;
    logic [7:0] avg_reg;
    logic [3:0] ana_applied;
    logic [7:0] rdata;
    logic [7:0] readback;
    logic       gain_hold;
    logic       win_start;
    logic       frame_start;
    logic [7:0] frame_val;
    logic       frame_done;
    logic       fcs_pend;
    logic [7:0] fcs_addr;
    logic       buf_wr;
    logic [7:0] buf_addr;
    logic [7:0] buf_data;
  } top_state_t;

  // window accumulator state
  typedef struct packed {
    logic        active;
    logic [23:0] cnt;
    logic [31:0] acc;
    logic        done;
    logic [31:0] sum;
    logic [23:0] count;
  } avg_state_t;

  // sequential divider state
  typedef struct packed {
    logic        busy;
    logic [5:0]  step;
    logic        neg;
    logic [31:0] num;
    logic [23:0] den;
    logic [24:0] rem;
    logic        done;
    logic [7:0]  quo;
  } div_state_t;

endpackage

// [hdl/rssi_window_sum.sv]
// Purpose : sums one signed sample per cycle over a window of cycles
// Assumes : win_cyc is at least one; samples on core_clk
// Notes   : with repeat_en high the next window starts right after done
module rssi_window_sum
  import rx_chain_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        start,       // begin a fresh window
  input  wire logic        run,         // level, drop ends the window
  input  wire logic        repeat_en,   // back to back windows
  input  wire logic [23:0] win_cyc,     // window length in cycles
  input  wire logic [7:0]  sample,      // signed dBm sample
  output logic             done,        // one-cycle pulse
  output logic [31:0]      sum,         // signed window sum
  output logic [23:0]      count        // samples in sum
);
  avg_state_t s_q, s_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] acc_n;
    acc_n  = s_q.acc + {{24{sample[7]}}, sample};
    s_d    = s_q;
    s_d.done = 1'b0;
    if (start && run) begin
      // a restart discards any partial window
      s_d.active = 1'b1;
      s_d.cnt    = 24'h000000;
      s_d.acc    = 32'h00000000;
    end else if (!run) begin
      s_d.active = 1'b0;
    end else if (s_q.active) begin
      if (s_q.cnt + 24'h000001 >= win_cyc) begin
        s_d.done   = 1'b1;
        s_d.sum    = acc_n;
        s_d.count  = s_q.cnt + 24'h000001;
        s_d.cnt    = 24'h000000;
        s_d.acc    = 32'h00000000;
        s_d.active = repeat_en;
      end else begin
        s_d.cnt = s_q.cnt + 24'h000001;
        s_d.acc = acc_n;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done  = s_q.done;
  assign sum   = s_q.sum;
  assign count = s_q.count;
endmodule

// [hdl/rssi_divider.sv]
// Purpose : signed sum divided by a sample count, one bit per cycle
// Assumes : quotient fits eight signed bits (a mean of 8-bit samples)
// Notes   : 32 cycles per result; a start while busy is ignored
module rssi_divider
  import rx_chain_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        start,      // one-cycle request
  input  wire logic [31:0] dividend,   // signed
  input  wire logic [23:0] divisor,    // unsigned, nonzero
  output logic             busy,       // level
  output logic             done,       // one-cycle pulse
  output logic [7:0]       quotient    // signed, truncated toward zero
);
  div_state_t s_q, s_d;

  // ----------------------------------------------------------------
  // restoring division on magnitudes
  // ----------------------------------------------------------------
  always_comb begin
    logic [24:0] rem_sh;
    rem_sh = {s_q.rem[23:0], s_q.num[31]};
    s_d    = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy) begin
      if (start) begin
        s_d.busy = 1'b1;
        s_d.step = 6'h00;
        s_d.neg  = dividend[31];
        s_d.num  = dividend[31] ? (32'h00000000 - dividend) : dividend;
        s_d.den  = divisor;
        s_d.rem  = 25'h0000000;
      end
    end else begin
      s_d.num = {s_q.num[30:0], 1'b0};
      if (rem_sh >= {1'b0, s_q.den}) begin
        s_d.rem    = rem_sh - {1'b0, s_q.den};
        s_d.num[0] = 1'b1;
      end else begin
        s_d.rem = rem_sh;
      end
      s_d.step = s_q.step + 6'h01;
      if (s_q.step == 6'h1F) begin
        // last bit: restore sign and publish
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.quo  = s_q.neg ? (8'h00 - s_d.num[7:0]) : s_d.num[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy     = s_q.busy;
  assign done     = s_q.done;
  assign quotient = s_q.quo;
endmodule

// [hdl/rx_signal_chain_control.sv]
// Purpose : receive chain control: filter bandwidths, offset correction and
//           gain sequencing, signal strength averaging and per-frame storing
// Assumes : one 10 MHz core_clk; all inputs come from logic on that clock
// Notes   : registers sit at their byte offsets on a simple register port

`include "rx_chain_params.svh"

module rx_signal_chain_control
  import rx_chain_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  // register port
  input  wire logic [`ADDR_W-1:0]    reg_addr,
  input  wire logic                  reg_wr_en,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_rd_en,
  output logic      [7:0]            reg_rdata,
  // radio controller events
  input  wire logic                  receive_command,
  input  wire logic                  idle_to_phy_ready,
  input  wire logic                  rx_active_start,
  input  wire logic                  rx_exit,
  input  wire logic                  preamble_detected,
  input  wire logic                  sfd_detected,
  input  wire logic                  frame_fcs_valid,
  input  wire logic [7:0]            frame_fcs_addr,
  // gain filter settings held elsewhere
  input  wire logic [2:0]            gain_filter_average_two,
  input  wire logic                  gain_lock_after_preamble,
  // raw strength sample from the gain loop
  input  wire logic [7:0]            rssi_sample,
  // front end controls
  output logic      [3:0]            analog_baseband_bandwidth,
  output logic      [1:0]            digital_filter_first_bandwidth,
  output logic      [2:0]            digital_filter_second_bandwidth,
  output logic                       offset_correction_loop_run,
  output logic                       gain_control_enable,
  output logic                       gain_control_hold,
  // receive buffer write port
  output logic                       rx_buf_wr_en,
  output logic      [7:0]            rx_buf_addr,
  output logic      [7:0]            rx_buf_wdata
);
  import rx_chain_pkg::*;

  top_state_t  s_q, s_d;           // whole block state
  logic        is_fsk;             // mode field selects FSK receive
  logic [4:0]  alpha;              // averaging exponent
  logic [31:0] win_ns;             // continuous window length, ns
  logic [31:0] frame_ns;           // frame window length, ns
  logic [23:0] win_cyc;            // continuous window, cycles
  logic [23:0] frame_cyc;          // frame window, cycles
  logic        cont_done;          // continuous window finished
  logic [31:0] cont_sum;
  logic [23:0] cont_count;
  logic        frame_win_done;     // frame window finished
  logic [31:0] frame_sum;
  logic [23:0] frame_count;
  logic        cont_div_busy;
  logic        cont_div_done;
  logic [7:0]  cont_mean;
  logic        frame_div_busy;
  logic        frame_div_done;
  logic [7:0]  frame_mean;
  logic        in_rx;              // active receive phase

  // ----------------------------------------------------------------
  // offset adjust with saturation to the signed byte range
  // ----------------------------------------------------------------
  function automatic logic [7:0] add_offset(input logic [7:0] raw,
                                            input logic [2:0] offs);
    logic signed [8:0] s;
    s = $signed({raw[7], raw}) + $signed({{6{offs[2]}}, offs});
    if (s > `RSSI_MAX) begin
      add_offset = 8'h7F;
    end else if (s < `RSSI_MIN) begin
      add_offset = 8'h80;
    end else begin
      add_offset = s[7:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // averaging window lengths
  // ----------------------------------------------------------------
  // least times round up to whole cycles
  always_comb begin
    logic [31:0] cyc_w;
    logic [31:0] cyc_f;
    cyc_w  = 32'h00000000;
    cyc_f  = 32'h00000000;
    is_fsk = (s_q.mode_reg == `MODE_FSK);
    alpha  = `ALPHA_BASE
           + {2'b00, s_q.avg_reg[`AVG1_MSB:`AVG1_LSB]}
           + {2'b00, gain_filter_average_two}
           + {3'b000, s_q.avg_reg[`AVG_TIME_MSB:`AVG_TIME_LSB]};
    // fixed period in 802.15.4 modes
    win_ns   = is_fsk ? (`AVG_UNIT_NS << alpha) : `IEEE_AVG_NS;
    frame_ns = `SYMBOL_NS * `FRAME_SYMBOLS;
    cyc_w    = (win_ns + `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS;
    cyc_f    = (frame_ns + `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS;
    win_cyc   = cyc_w[23:0];
    frame_cyc = cyc_f[23:0];
  end

  assign in_rx = (s_q.phase == ST_RX);

  // ----------------------------------------------------------------
  // window sums and their dividers
  // ----------------------------------------------------------------
  // continuous window, back to back while receiving
  rssi_window_sum u_cont_sum (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .start     (s_q.win_start),
    .run       (in_rx),
    .repeat_en (1'b1),
    .win_cyc   (win_cyc),
    .sample    (rssi_sample),
    .done      (cont_done),
    .sum       (cont_sum),
    .count     (cont_count)
  );

  // one window per detected frame
  rssi_window_sum u_frame_sum (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .start     (s_q.frame_start),
    .run       (in_rx),
    .repeat_en (1'b0),
    .win_cyc   (frame_cyc),
    .sample    (rssi_sample),
    .done      (frame_win_done),
    .sum       (frame_sum),
    .count     (frame_count)
  );

  // short windows can outpace the divider; such results are skipped
  rssi_divider u_cont_div (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .start    (cont_done),
    .dividend (cont_sum),
    .divisor  (cont_count),
    .busy     (cont_div_busy),
    .done     (cont_div_done),
    .quotient (cont_mean)
  );

  rssi_divider u_frame_div (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .start    (frame_win_done),
    .dividend (frame_sum),
    .divisor  (frame_count),
    .busy     (frame_div_busy),
    .done     (frame_div_done),
    .quotient (frame_mean)
  );

  // ----------------------------------------------------------------
  // next state of the block
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.win_start   = 1'b0;
    s_d.frame_start = 1'b0;
    s_d.buf_wr      = 1'b0;

    // register writes, readback is read only
    if (reg_wr_en) begin
      case (reg_addr)
        `REG_MODE:    s_d.mode_reg = reg_wdata;
        `REG_DIGFILT: s_d.dig_reg  = reg_wdata;
        `REG_ANAFILT: s_d.ana_reg  = reg_wdata;
        `REG_AVGCFG:  s_d.avg_reg  = reg_wdata;
        default:      s_d.mode_reg = s_q.mode_reg;
      endcase
    end

    // register reads, answer held until the next read
    if (reg_rd_en) begin
      case (reg_addr)
        `REG_MODE:     s_d.rdata = s_q.mode_reg;
        `REG_READBACK: s_d.rdata = s_q.readback;
        `REG_DIGFILT:  s_d.rdata = s_q.dig_reg;
        `REG_ANAFILT:  s_d.rdata = s_q.ana_reg;
        `REG_AVGCFG:   s_d.rdata = s_q.avg_reg;
        default:       s_d.rdata = 8'h00;
      endcase
    end

    // the analog filter only takes a new setting on idle to ready
    if (idle_to_phy_ready) begin
      s_d.ana_applied = s_q.ana_reg[`ANA_BW_MSB:`ANA_BW_LSB];
    end

    // receive sequencing
    case (s_q.phase)
      ST_IDLE: begin
        s_d.phase = ST_IDLE;
      end
      ST_CAL: begin
        // gain control follows the correction phase only on rx_active_start
        if (rx_active_start) begin
          s_d.phase     = ST_RX;
          s_d.win_start = 1'b1;
        end
      end
      ST_RX: begin
        if (preamble_detected && is_fsk && gain_lock_after_preamble) begin
          s_d.gain_hold = 1'b1;
        end
        if (sfd_detected && (s_q.mode_reg == `MODE_PKT_154)) begin
          s_d.frame_start = 1'b1;
          s_d.frame_done  = 1'b0;
          s_d.fcs_pend    = 1'b0;
        end
      end
      default: begin
        s_d.phase = ST_IDLE;
      end
    endcase
    if (rx_exit) begin
      s_d.phase = ST_IDLE;
    end
    // a receive command always restarts calibration, even mid receive
    if (receive_command) begin
      s_d.phase     = ST_CAL;
      s_d.gain_hold = 1'b0;
    end

    // continuous readback while receiving
    if (cont_div_done && in_rx) begin
      s_d.readback = add_offset(cont_mean,
                                s_q.avg_reg[`OFFS_MSB:`OFFS_LSB]);
    end

    // per-frame result meets the frame's first check byte position
    if (frame_div_done) begin
      s_d.frame_val  = add_offset(frame_mean,
                                  s_q.avg_reg[`OFFS_MSB:`OFFS_LSB]);
      s_d.frame_done = 1'b1;
    end
    if (frame_fcs_valid) begin
      s_d.fcs_addr = frame_fcs_addr;
      s_d.fcs_pend = 1'b1;
    end
    if (s_d.frame_done && s_d.fcs_pend) begin
      s_d.buf_wr     = 1'b1;
      s_d.buf_addr   = s_d.fcs_addr;
      s_d.buf_data   = s_d.frame_val;
      s_d.frame_done = 1'b0;
      s_d.fcs_pend   = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q          <= '0;
      s_q.phase    <= ST_IDLE;
      s_q.mode_reg <= `MODE_RST;
      s_q.dig_reg  <= `DIGFILT_RST;
      s_q.ana_reg  <= `ANAFILT_RST;
      s_q.avg_reg  <= `AVGCFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata                       = s_q.rdata;
  assign analog_baseband_bandwidth       = s_q.ana_applied;
  assign digital_filter_first_bandwidth  = s_q.dig_reg[`DIG1_MSB:`DIG1_LSB];
  assign digital_filter_second_bandwidth = s_q.dig_reg[`DIG2_MSB:`DIG2_LSB];
  // correction runs in calibration always, in receive only for 802.15.4
  assign offset_correction_loop_run =
    (s_q.phase == ST_CAL) || (in_rx && !is_fsk);
  assign gain_control_enable = in_rx;
  assign gain_control_hold   = s_q.gain_hold;
  assign rx_buf_wr_en        = s_q.buf_wr;
  assign rx_buf_addr         = s_q.buf_addr;
  assign rx_buf_wdata        = s_q.buf_data;
endmodule

// [dv/rx_chain_monitor.sv]
// Purpose: port checks of rx_signal_chain_control
// Assumes: one clock, async active-low reset
// Notes:   mode and analog fields shadowed from writes
`include "rx_chain_params.svh"
module rx_chain_monitor (
  input wire logic               core_clk,
  input wire logic               arst_n,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic               reg_wr_en,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_rd_en,
  input wire logic [7:0]         reg_rdata,
  input wire logic               receive_command,
  input wire logic               idle_to_phy_ready,
  input wire logic               rx_active_start,
  input wire logic               preamble_detected,
  input wire logic               gain_lock_after_preamble,
  input wire logic [3:0]         analog_baseband_bandwidth,
  input wire logic [1:0]         digital_filter_first_bandwidth,
  input wire logic [2:0]         digital_filter_second_bandwidth,
  input wire logic               offset_correction_loop_run,
  input wire logic               gain_control_enable,
  input wire logic               gain_control_hold,
  input wire logic               rx_buf_wr_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mode_q; // shadow of mode register
  logic [3:0] ana_q;  // shadow of written analog field
  // ----------------------------------------
  // shadow registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= 8'h00;
      ana_q  <= 4'h0;
    end else if (reg_wr_en) begin
      if (reg_addr == `REG_MODE) mode_q <= reg_wdata;
      if (reg_addr == `REG_ANAFILT) ana_q <= reg_wdata[3:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_cal; receive_command |=> offset_correction_loop_run && !gain_control_enable; endproperty
  a_cal: assert property (p_cal) else $error("no calibration after command");
  property p_gain; $rose(gain_control_enable) |-> $past(rx_active_start); endproperty
  a_gain: assert property (p_gain) else $error("gain on without receive start");
  property p_fsk; gain_control_enable && mode_q == `MODE_FSK |-> !offset_correction_loop_run;
  endproperty
  a_fsk: assert property (p_fsk) else $error("offset loop runs in fsk receive");
  property p_ieee; gain_control_enable && mode_q == 8'h00 |-> offset_correction_loop_run;
  endproperty
  a_ieee: assert property (p_ieee) else $error("offset loop stopped in packet mode");
  property p_dig; reg_wr_en && reg_addr == `REG_DIGFILT |=>
    {3'b000, digital_filter_second_bandwidth, digital_filter_first_bandwidth}
      == ($past(reg_wdata) & 8'h1F);
  endproperty
  a_dig: assert property (p_dig) else $error("digital filter fields wrong");
  property p_hold; !idle_to_phy_ready |=> $stable(analog_baseband_bandwidth); endproperty
  a_hold: assert property (p_hold) else $error("analog field moved early");
  property p_ana; idle_to_phy_ready && !reg_wr_en |=> analog_baseband_bandwidth == ana_q;
  endproperty
  a_ana: assert property (p_ana) else $error("analog field not applied");
  property p_lock; gain_control_enable && mode_q == `MODE_FSK && gain_lock_after_preamble
    && preamble_detected |=> gain_control_hold[*3]; endproperty
  a_lock: assert property (p_lock) else $error("gain not locked after preamble");
  property p_buf; rx_buf_wr_en |-> mode_q == `MODE_PKT_154 ##1 !rx_buf_wr_en; endproperty
  a_buf: assert property (p_buf) else $error("bad buffer write");
  property p_mode; reg_rd_en && !reg_wr_en && reg_addr == `REG_MODE |=> reg_rdata == mode_q;
  endproperty
  a_mode: assert property (p_mode) else $error("mode readback wrong");
endmodule
bind rx_signal_chain_control rx_chain_monitor u_mon (.core_clk, .arst_n, .reg_addr, .reg_wr_en,
  .reg_wdata, .reg_rd_en, .reg_rdata, .receive_command, .idle_to_phy_ready, .rx_active_start,
  .preamble_detected, .gain_lock_after_preamble, .analog_baseband_bandwidth,
  .digital_filter_first_bandwidth, .digital_filter_second_bandwidth,
  .offset_correction_loop_run, .gain_control_enable, .gain_control_hold, .rx_buf_wr_en);

// [dv/rx_signal_chain_control_tb.sv]
// Purpose: self-checking bench of rx_signal_chain_control
// Assumes: inputs change at the falling edge
// Notes:   read and buffer results compared by a monitor
module rx_signal_chain_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rx_chain_pkg::*;
  logic        core_clk = 1'b0;
  logic        arst_n   = 1'b0;
  logic [9:0]  reg_addr;
  logic [7:0]  reg_wdata, frame_fcs_addr, rssi_sample, reg_rdata, rx_buf_addr, rx_buf_wdata;
  logic        reg_wr_en, reg_rd_en, receive_command, idle_to_phy_ready, rx_active_start;
  logic        rx_exit, preamble_detected, sfd_detected, frame_fcs_valid;
  logic        gain_lock_after_preamble, rx_buf_wr_en, rd_p;
  logic [2:0]  gain_filter_average_two, digital_filter_second_bandwidth, offs;
  logic [3:0]  analog_baseband_bandwidth;
  logic [1:0]  digital_filter_first_bandwidth;
  logic        offset_correction_loop_run, gain_control_enable, gain_control_hold;
  logic [31:0] rnd = 32'h81145388; // xorshift state
  logic [15:0] exp_q[$];           // expected results, oldest first
  logic [7:0]  smp, e;
  logic [9:0]  amap[5] = '{10'h13E, 10'h389, 10'h39B, 10'h3B9, 10'h3FF};
  logic [7:0]  md[2] = '{8'h03, 8'h00};
  int          n_fail, num_checks, cyc;
  rx_signal_chain_control DUT (.core_clk, .arst_n, .reg_addr, .reg_wr_en, .reg_wdata,
    .reg_rd_en, .reg_rdata, .receive_command, .idle_to_phy_ready, .rx_active_start, .rx_exit,
    .preamble_detected, .sfd_detected, .frame_fcs_valid, .frame_fcs_addr,
    .gain_filter_average_two, .gain_lock_after_preamble, .rssi_sample,
    .analog_baseband_bandwidth, .digital_filter_first_bandwidth,
    .digital_filter_second_bandwidth, .offset_correction_loop_run, .gain_control_enable,
    .gain_control_hold, .rx_buf_wr_en, .rx_buf_addr, .rx_buf_wdata);
  always #50 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] got);
    num_checks++;
    if (ex !== got) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, ex, got);
    end
  endtask
  // spare cycle so back to back calls never drive one strobe twice at once
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    pulse(reg_wr_en);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] d);
    reg_addr = a;
    exp_q.push_back({8'h00, d});
    pulse(reg_rd_en);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // result monitor and hang guard
  // ----------------------------------------
  always @(posedge core_clk) begin
    rd_p <= reg_rd_en;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  always @(negedge core_clk) begin
    if (rd_p || rx_buf_wr_en) begin
      if (exp_q.size() == 0) chk("unexpected", 16'hFFFF, {rx_buf_addr, rx_buf_wdata});
      else if (rx_buf_wr_en) chk("buffer", exp_q.pop_front(), {rx_buf_addr, rx_buf_wdata});
      else chk("rdata", exp_q.pop_front(), {8'h00, reg_rdata});
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reg_addr, reg_wdata, frame_fcs_addr, rssi_sample, reg_wr_en, reg_rd_en} = '0;
    {receive_command, idle_to_phy_ready, rx_active_start, rx_exit, preamble_detected} = '0;
    {sfd_detected, frame_fcs_valid, gain_lock_after_preamble, gain_filter_average_two} = '0;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    foreach (amap[i]) rd(amap[i], 8'h00);
    rnd = xs(rnd);
    wr(10'h389, rnd[7:0]);
    rd(10'h389, rnd[7:0]);
    chk("digital", 16'(rnd[4:0]), 16'({digital_filter_second_bandwidth,
      digital_filter_first_bandwidth}));
    wr(10'h30C, 8'hA5);
    rd(10'h30C, 8'h00);
    wr(10'h39B, {4'h0, rnd[11:9], 1'b1});
    chk("analog early", 16'h0, 16'(analog_baseband_bandwidth));
    pulse(idle_to_phy_ready);
    chk("analog", 16'({rnd[11:9], 1'b1}), 16'(analog_baseband_bandwidth));
    $display("test registers done");
    foreach (md[i]) begin
      rnd = xs(rnd);
      smp = {rnd[6], rnd[6:0]};
      offs = rnd[10:8];
      e = smp + {{5{offs[2]}}, offs};
      rssi_sample = smp;
      gain_lock_after_preamble = 1'b1;
      wr(10'h13E, md[i]);
      wr(10'h3B9, {3'b000, offs, 2'b00});
      pulse(receive_command);
      chk("calibrate", 16'h2, 16'({offset_correction_loop_run, gain_control_enable}));
      repeat (3) @(negedge core_clk);
      pulse(rx_active_start);
      chk("receive", 16'({md[i] != 8'h03, 1'b1}),
        16'({offset_correction_loop_run, gain_control_enable}));
      pulse(preamble_detected);
      chk("lock", 16'(md[i] == 8'h03), 16'(gain_control_hold));
      if (md[i] == 8'h03) begin
        repeat (100) @(negedge core_clk);
      end else begin
        frame_fcs_addr = rnd[23:16];
        exp_q.push_back({rnd[23:16], e});
        pulse(sfd_detected);
        pulse(frame_fcs_valid);
        for (int k = 0; k < 1500 && exp_q.size() != 0; k++) @(negedge core_clk);
      end
      rd(10'h30C, e);
      pulse(rx_exit);
      chk("exit", 16'h0, 16'(gain_control_enable));
      $display("test mode %h done", md[i]);
    end
    repeat (2) @(negedge core_clk);
    chk("pending", 16'h0, 16'(exp_q.size()));
    give_verdict();
  end
endmodule
